//--- include/rcs_map.svh
`ifndef RCS_MAP_SVH
`define RCS_MAP_SVH

// register addresses (read address; write address has bit 7 set)
`define RCS_ADDR_CTRL_BASE 7'h00
`define RCS_ADDR_CTRL_SPLIT 7'h0d
`define RCS_ADDR_STATUS 7'h0e
`define RCS_ADDR_TRICKLE 7'h0f
`define RCS_ADDR_RW_BIT 7

// reset values
`define RCS_CTRL_RST 8'h18
`define RCS_STATUS_RST 8'h80
`define RCS_TRICKLE_RST 8'h00

// control register layout
`define RCS_CTRL_RW_MASK 8'hbd
`define RCS_CTRL_OSC_STOP 7
`define RCS_CTRL_BACKUP_OE 5
`define RCS_CTRL_RATE_HI 4
`define RCS_CTRL_RATE_LO 3
`define RCS_CTRL_IRQ_WAVE 2
`define RCS_CTRL_ALARM_IE 0

// status register layout
`define RCS_STAT_OSC_HALT 7
`define RCS_STAT_ALARM 0

// trickle-charge layout and codes
`define RCS_TC_KEY_HI 7
`define RCS_TC_KEY_LO 4
`define RCS_TC_DIODE_HI 3
`define RCS_TC_DIODE_LO 2
`define RCS_TC_RES_HI 1
`define RCS_TC_RES_LO 0
`define RCS_TC_KEY 4'ha
`define RCS_TC_DIODE_NONE 2'h1
`define RCS_TC_DIODE_ONE 2'h2
`define RCS_TC_RES_OFF 2'h0

// serial framing
`define RCS_BIT_LAST 3'h7

`endif

//--- include/rcs_pkg.sv
`default_nettype none

package rcs_pkg;

	typedef enum logic [1:0] {
		RCS_VAR_COMBINED,
		RCS_VAR_RESET,
		RCS_VAR_SPLIT
	} rcs_variant_t;

	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] status;
		logic [7:0] trickle;
	} rcs_snap_t;

	typedef struct packed {
		logic [6:0] addr;
		logic [7:0] data;
	} rcs_wr_t;

endpackage : rcs_pkg

`default_nettype wire

//--- hw/rcs_regs.sv
// Contract
// - oscillator runs when stop bit 0; stops only on backup when 1
// - oscillator-stop bit clears to 0 at first power
// - backup-output-enable 0 floats wave/irq pins on backup power
// - backup-output-enable bit clears to 0 at first power
// - rate bits 00/01/10/11 pick 1Hz/4.096k/8.192k/32.768kHz
// - both rate bits set to 1 at first power
// - select bit 0 puts square wave on pin while oscillator enabled
// - select 1 with alarm enable drives pin on alarm match
// - alarm match flag sets on every match regardless of select
// - irq-or-wave select bit clears to 0 at first power
// - alarm flag drives pin only when enable and select both 1
// - alarm interrupt enable clears to 0 at first power
// - halted flag sets when oscillator goes from running to stopped
// - halted flag holds 1 until written 0; writing 1 no effect
// - alarm flag at bit 0 clears on write 0, write 1 ignored
// - charger enabled only with key 1010 in bits 7 to 4
// - diode bits 01 none, 10 one, 00 or 11 disable
// - resistor bits 01/10/11 pick 250/2k/4k, 00 disables
// - trickle register loads all zeros at first power
// - reset-pin variant keeps non-oscillator control bits as storage
// - split-pin variant: bit 2 active-low wave enable, resets 0
// - data out floats while select high and until read byte ready
// - first byte is address; its msb 1 writes, 0 reads
`include "rcs_map.svh"
`default_nettype none

module rcs_regs
	import rcs_pkg::*;
#(
	parameter rcs_variant_t VARIANT = RCS_VAR_COMBINED
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_vcc_valid,
	input wire logic i_osc_running,
	input wire logic i_alarm_match,
	input wire logic [3:0] i_wave_taps,
	input wire logic i_spi_sclk,
	input wire logic i_spi_cs_n,
	input wire logic i_spi_mosi,
	output logic o_spi_miso,
	output logic o_spi_miso_oe_n,
	output logic o_osc_enable,
	output logic o_wave_irq_pin_o,
	output logic o_wave_irq_pin_oe_n,
	output logic o_irq_pin_o,
	output logic o_irq_pin_oe_n,
	output logic o_charge_enable,
	output logic o_charge_diode,
	output logic [1:0] o_charge_res_sel
);

	localparam logic [7:0] STAT_RST = `RCS_STATUS_RST;
	localparam logic [6:0] CTRL_ADDR = (VARIANT == RCS_VAR_SPLIT) ?
		`RCS_ADDR_CTRL_SPLIT : `RCS_ADDR_CTRL_BASE;

	function automatic logic [7:0] rd_byte(input rcs_snap_t s,
		input logic [6:0] a);
		logic [7:0] r;
		r = 8'h00;
		if (a == CTRL_ADDR) begin
			r = s.ctrl;
		end else if (a == `RCS_ADDR_STATUS) begin
			r = s.status;
		end else if (a == `RCS_ADDR_TRICKLE) begin
			r = s.trickle;
		end
		return r;
	endfunction : rd_byte

	// ---------------- system clock domain ----------------

	logic [6:0] pin_s1_q;
	logic [6:0] pin_s2_q;
	logic [6:0] pin_s3_q;
	logic vcc_ok;
	logic osc_run;
	logic [3:0] taps;
	logic alarm_rise;
	logic osc_fall;

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			pin_s1_q <= 7'h00;
			pin_s2_q <= 7'h00;
			pin_s3_q <= 7'h00;
		end else begin
			pin_s1_q <= {i_wave_taps, i_alarm_match, i_osc_running,
				i_vcc_valid};
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
		end
	end

	assign vcc_ok = pin_s2_q[0];
	assign osc_run = pin_s2_q[1];
	assign taps = pin_s2_q[6:3];
	assign alarm_rise = pin_s2_q[2] & ~pin_s3_q[2];
	assign osc_fall = ~pin_s2_q[1] & pin_s3_q[1];

	// write events arrive as a toggle; the held word is stable by then
	logic wr_tgl_q;
	rcs_wr_t wr_hold_q;
	logic wt_s1_q;
	logic wt_s2_q;
	logic wt_s3_q;
	logic wr_ev;
	logic wr_ctrl;
	logic wr_stat;
	logic wr_tc;

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			wt_s1_q <= 1'b0;
			wt_s2_q <= 1'b0;
			wt_s3_q <= 1'b0;
		end else begin
			wt_s1_q <= wr_tgl_q;
			wt_s2_q <= wt_s1_q;
			wt_s3_q <= wt_s2_q;
		end
	end

	assign wr_ev = wt_s2_q ^ wt_s3_q;
	assign wr_ctrl = wr_ev && (wr_hold_q.addr == CTRL_ADDR);
	assign wr_stat = wr_ev && (wr_hold_q.addr == `RCS_ADDR_STATUS);
	assign wr_tc = wr_ev && (wr_hold_q.addr == `RCS_ADDR_TRICKLE);

	logic [7:0] ctrl_q;
	logic osc_halted_flag_q;
	logic alarm_match_flag_q;
	logic [7:0] trickle_q;

	// unused control bits read zero; in the reset-pin variant all but the
	// oscillator-stop bit act as plain storage
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			ctrl_q <= `RCS_CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_q <= wr_hold_q.data & `RCS_CTRL_RW_MASK;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			osc_halted_flag_q <= STAT_RST[`RCS_STAT_OSC_HALT];
		end else if (osc_fall) begin
			osc_halted_flag_q <= 1'b1;
		end else if (wr_stat && !wr_hold_q.data[`RCS_STAT_OSC_HALT]) begin
			osc_halted_flag_q <= 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			alarm_match_flag_q <= STAT_RST[`RCS_STAT_ALARM];
		end else if (alarm_rise) begin
			alarm_match_flag_q <= 1'b1;
		end else if (wr_stat && !wr_hold_q.data[`RCS_STAT_ALARM]) begin
			alarm_match_flag_q <= 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			trickle_q <= `RCS_TRICKLE_RST;
		end else if (wr_tc) begin
			trickle_q <= wr_hold_q.data;
		end
	end

	// control fields
	logic osc_stop_on_backup;
	logic backup_output_enable;
	logic rate_sel_hi;
	logic rate_sel_lo;
	logic irq_or_wave_sel;
	logic alarm_irq_enable;
	logic [3:0] charge_unlock_key;
	logic [1:0] diode_sel;
	logic [1:0] resistor_sel;

	assign osc_stop_on_backup = ctrl_q[`RCS_CTRL_OSC_STOP];
	assign backup_output_enable = ctrl_q[`RCS_CTRL_BACKUP_OE];
	assign rate_sel_hi = ctrl_q[`RCS_CTRL_RATE_HI];
	assign rate_sel_lo = ctrl_q[`RCS_CTRL_RATE_LO];
	assign irq_or_wave_sel = ctrl_q[`RCS_CTRL_IRQ_WAVE];
	assign alarm_irq_enable = ctrl_q[`RCS_CTRL_ALARM_IE];
	assign charge_unlock_key = trickle_q[`RCS_TC_KEY_HI:`RCS_TC_KEY_LO];
	assign diode_sel = trickle_q[`RCS_TC_DIODE_HI:`RCS_TC_DIODE_LO];
	assign resistor_sel = trickle_q[`RCS_TC_RES_HI:`RCS_TC_RES_LO];

	logic osc_en_d;
	logic wave_sel;
	logic wave_on;
	logic out_allowed;
	logic irq_act;
	logic wave_irq_drive_d;
	logic irq_drive_d;
	logic charge_en_d;

	always_comb begin
		osc_en_d = vcc_ok | ~osc_stop_on_backup;
		// taps: 0 1Hz, 1 4.096k, 2 8.192k, 3 32.768k
		wave_sel = taps[{rate_sel_hi, rate_sel_lo}];
		wave_on = osc_en_d & osc_run & ~wave_sel;
		out_allowed = vcc_ok | backup_output_enable;
		irq_act = alarm_match_flag_q & alarm_irq_enable;
		wave_irq_drive_d = 1'b0;
		irq_drive_d = 1'b0;
		case (VARIANT)
			RCS_VAR_COMBINED: begin
				if (irq_or_wave_sel) begin
					wave_irq_drive_d = out_allowed & irq_act;
				end else begin
					wave_irq_drive_d = out_allowed & wave_on;
				end
			end
			RCS_VAR_SPLIT: begin
				wave_irq_drive_d = out_allowed & ~irq_or_wave_sel &
					wave_on;
				irq_drive_d = out_allowed & irq_act;
			end
			default: begin
				wave_irq_drive_d = 1'b0;
				irq_drive_d = 1'b0;
			end
		endcase
		charge_en_d = (charge_unlock_key == `RCS_TC_KEY) &&
			((diode_sel == `RCS_TC_DIODE_NONE) ||
			(diode_sel == `RCS_TC_DIODE_ONE)) &&
			(resistor_sel != `RCS_TC_RES_OFF);
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_osc_enable <= 1'b1;
			o_wave_irq_pin_o <= 1'b0;
			o_wave_irq_pin_oe_n <= 1'b1;
			o_irq_pin_o <= 1'b0;
			o_irq_pin_oe_n <= 1'b1;
		end else begin
			o_osc_enable <= osc_en_d;
			o_wave_irq_pin_o <= 1'b0;
			o_wave_irq_pin_oe_n <= ~wave_irq_drive_d;
			o_irq_pin_o <= 1'b0;
			o_irq_pin_oe_n <= ~irq_drive_d;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_charge_enable <= 1'b0;
			o_charge_diode <= 1'b0;
			o_charge_res_sel <= 2'h0;
		end else begin
			o_charge_enable <= charge_en_d;
			o_charge_diode <= charge_en_d &&
				(diode_sel == `RCS_TC_DIODE_ONE);
			o_charge_res_sel <= charge_en_d ? resistor_sel : 2'h0;
		end
	end

	// register image handed to the link by a toggle handshake
	rcs_snap_t live;
	rcs_snap_t snap_q;
	logic snap_req_q;
	logic snap_ack_q;
	logic ack_s1_q;
	logic ack_s2_q;

	always_comb begin
		live.ctrl = ctrl_q;
		live.status = 8'h00;
		live.status[`RCS_STAT_OSC_HALT] = osc_halted_flag_q;
		live.status[`RCS_STAT_ALARM] = alarm_match_flag_q;
		live.trickle = trickle_q;
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			ack_s1_q <= 1'b0;
			ack_s2_q <= 1'b0;
		end else begin
			ack_s1_q <= snap_ack_q;
			ack_s2_q <= ack_s1_q;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			snap_q <= {`RCS_CTRL_RST, `RCS_STATUS_RST, `RCS_TRICKLE_RST};
			snap_req_q <= 1'b0;
		end else if ((snap_req_q == ack_s2_q) && (live != snap_q)) begin
			snap_q <= live;
			snap_req_q <= ~snap_req_q;
		end
	end

	// ---------------- link clock domain ----------------

	logic lrst_s1_q;
	logic lrst_s2_q;
	logic req_s1_q;
	logic req_s2_q;
	rcs_snap_t copy_q;

	always_ff @(posedge i_spi_sclk) begin
		lrst_s1_q <= i_rst;
		lrst_s2_q <= lrst_s1_q;
	end

	always_ff @(posedge i_spi_sclk) begin
		if (lrst_s2_q) begin
			req_s1_q <= 1'b0;
			req_s2_q <= 1'b0;
			snap_ack_q <= 1'b0;
			copy_q <= {`RCS_CTRL_RST, `RCS_STATUS_RST, `RCS_TRICKLE_RST};
		end else begin
			req_s1_q <= snap_req_q;
			req_s2_q <= req_s1_q;
			if (req_s2_q != snap_ack_q) begin
				copy_q <= snap_q;
				snap_ack_q <= req_s2_q;
			end
		end
	end

	logic [2:0] bit_cnt_q;
	logic have_addr_q;
	logic write_q;
	logic [6:0] addr_q;
	logic [7:0] sh_q;
	logic [7:0] out_sh_q;
	logic [7:0] sh_nx;
	logic [6:0] next_addr;
	logic [7:0] rb;
	logic byte_end;

	always_comb begin
		sh_nx = {sh_q[6:0], i_spi_mosi};
		next_addr = {addr_q[6:4], 4'(addr_q[3:0] + 4'h1)};
		rb = rd_byte(copy_q, have_addr_q ? next_addr : sh_nx[6:0]);
		byte_end = (bit_cnt_q == `RCS_BIT_LAST);
	end

	// frame state is cleared whenever select is high
	always_ff @(posedge i_spi_sclk or posedge i_spi_cs_n) begin
		if (i_spi_cs_n) begin
			bit_cnt_q <= 3'h0;
			have_addr_q <= 1'b0;
			write_q <= 1'b0;
			addr_q <= 7'h00;
			sh_q <= 8'h00;
			out_sh_q <= 8'h00;
			o_spi_miso <= 1'b0;
			o_spi_miso_oe_n <= 1'b1;
		end else begin
			sh_q <= sh_nx;
			bit_cnt_q <= 3'(bit_cnt_q + 3'h1);
			if (byte_end && !have_addr_q) begin
				have_addr_q <= 1'b1;
				write_q <= sh_nx[`RCS_ADDR_RW_BIT];
				addr_q <= sh_nx[6:0];
				if (!sh_nx[`RCS_ADDR_RW_BIT]) begin
					out_sh_q <= rb;
					o_spi_miso <= rb[7];
					o_spi_miso_oe_n <= 1'b0;
				end
			end else if (byte_end) begin
				addr_q <= next_addr;
				if (!write_q) begin
					out_sh_q <= rb;
					o_spi_miso <= rb[7];
				end
			end else if (have_addr_q && !write_q) begin
				out_sh_q <= {out_sh_q[6:0], 1'b0};
				o_spi_miso <= out_sh_q[6];
			end
		end
	end

	// completed write byte: hold the word and flip the event toggle
	always_ff @(posedge i_spi_sclk) begin
		if (lrst_s2_q) begin
			wr_tgl_q <= 1'b0;
			wr_hold_q <= '0;
		end else if (!i_spi_cs_n && byte_end && have_addr_q && write_q) begin
			wr_hold_q <= {addr_q, sh_nx};
			wr_tgl_q <= ~wr_tgl_q;
		end
	end

endmodule : rcs_regs

`default_nettype wire

//--- testbench/rcs_regs_sva.sv
`default_nettype none

module rcs_regs_chk (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_vcc_valid,
	input wire logic i_spi_cs_n,
	input wire logic o_spi_miso_oe_n,
	input wire logic o_osc_enable,
	input wire logic o_wave_irq_pin_o,
	input wire logic o_irq_pin_o,
	input wire logic o_irq_pin_oe_n,
	input wire logic o_wave_irq_pin_oe_n,
	input wire logic o_charge_enable,
	input wire logic o_charge_diode,
	input wire logic [1:0] o_charge_res_sel
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);

	osc_on_a: assert property (
		i_vcc_valid [*5] |-> o_osc_enable)
		else $error("oscillator off on main supply");
	rst_out_a: assert property (
		$fell(i_rst) |-> o_osc_enable && o_wave_irq_pin_oe_n
			&& !o_charge_enable)
		else $error("outputs wrong after reset");
	miso_z_a: assert property (
		i_spi_cs_n [*3] |-> o_spi_miso_oe_n)
		else $error("data out driven while deselected");
	chg_off_a: assert property (
		!o_charge_enable |-> !o_charge_diode && o_charge_res_sel == 2'h0)
		else $error("charger path set while disabled");
	chg_res_a: assert property (
		o_charge_enable |-> o_charge_res_sel != 2'h0)
		else $error("charger on without resistor");
	chg_hold_a: assert property (
		i_spi_cs_n [*8] |-> $stable(o_charge_enable)
			&& $stable(o_charge_res_sel))
		else $error("charger changed without a write");
	irq_idle_a: assert property (
		o_irq_pin_oe_n && !o_irq_pin_o)
		else $error("separate irq pin driven");
	pin_low_a: assert property (
		!o_wave_irq_pin_o)
		else $error("open drain pin value not low");
endmodule : rcs_regs_chk

bind rcs_regs rcs_regs_chk rcs_regs_chk_i (.i_sys_clk, .i_rst,
	.i_vcc_valid, .i_spi_cs_n, .o_spi_miso_oe_n, .o_osc_enable,
	.o_wave_irq_pin_o, .o_irq_pin_o, .o_irq_pin_oe_n,
	.o_wave_irq_pin_oe_n, .o_charge_enable, .o_charge_diode,
	.o_charge_res_sel);

`default_nettype wire

//--- testbench/rcs_host.sv
`default_nettype none

module rcs_host (
	output logic o_sclk,
	output logic o_cs_n,
	output logic o_mosi,
	input wire logic i_miso
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_mosi = 1'b0;
	end

	// shift clock edges with select high, for the link-side reset
	task automatic idle_clk();
		repeat (4) begin
			#24 o_sclk = 1'b1;
			#24 o_sclk = 1'b0;
		end
	endtask : idle_clk

	task automatic xfer(input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		logic [15:0] w;
		w = {a, d};
		q = 8'h00;
		o_cs_n = 1'b0;
		for (int k = 15; k >= 0; k--) begin
			o_mosi = w[k];
			#24;
			if (k < 8)
				q = {q[6:0], i_miso};
			o_sclk = 1'b1;
			#24 o_sclk = 1'b0;
		end
		#24 o_cs_n = 1'b1;
		o_mosi = ~o_mosi;
	endtask : xfer
endmodule : rcs_host

`default_nettype wire

//--- testbench/testbench.sv
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_sys_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_vcc_valid = 1'b1;
	logic i_osc_running = 1'b1;
	logic i_alarm_match = 1'b0;
	logic [3:0] i_wave_taps = 4'h0;
	wire i_spi_sclk, i_spi_cs_n, i_spi_mosi;
	logic o_spi_miso, o_spi_miso_oe_n, o_osc_enable, o_wave_irq_pin_o;
	logic o_wave_irq_pin_oe_n, o_irq_pin_o, o_irq_pin_oe_n;
	logic o_charge_enable, o_charge_diode;
	logic [1:0] o_charge_res_sel;
	logic [7:0] q;
	int err_total = 0;
	int n_compared = 0;

	always #4 i_sys_clk = ~i_sys_clk;

	rcs_regs rcs_regs_i (.i_sys_clk, .i_rst, .i_vcc_valid, .i_osc_running,
		.i_alarm_match, .i_wave_taps, .i_spi_sclk, .i_spi_cs_n, .i_spi_mosi,
		.o_spi_miso, .o_spi_miso_oe_n, .o_osc_enable, .o_wave_irq_pin_o,
		.o_wave_irq_pin_oe_n, .o_irq_pin_o, .o_irq_pin_oe_n,
		.o_charge_enable, .o_charge_diode, .o_charge_res_sel);
	rcs_host rcs_host_i (.o_sclk(i_spi_sclk), .o_cs_n(i_spi_cs_n),
		.o_mosi(i_spi_mosi), .i_miso(o_spi_miso));

	task automatic chk(input string n, input logic [7:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", n, exp, got);
		end
	endtask : chk

	task automatic wt(input int n);
		repeat (n) @(posedge i_sys_clk);
	endtask : wt

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		rcs_host_i.xfer({1'b1, a}, d, q);
		wt(8);
	endtask : wr

	task automatic rd(input logic [6:0] a, input logic [7:0] e, string n);
		rcs_host_i.xfer({1'b0, a}, 8'h00, q);
		chk(n, q, e);
		wt(2);
	endtask : rd

	task automatic t_reset();
		rd(7'h00, 8'h18, "ctrl");
		rd(7'h0e, 8'h80, "status");
		rd(7'h0f, 8'h00, "trickle");
		rd(7'h05, 8'h00, "unmapped");
		chk("osc_en", o_osc_enable, 8'h01);
	endtask : t_reset

	task automatic t_osc();
		wr(7'h00, 8'hff);
		rd(7'h00, 8'hbd, "ctrl_rw");
		i_vcc_valid <= 1'b0;
		wt(8);
		chk("osc_stop", o_osc_enable, 8'h00);
		i_vcc_valid <= 1'b1;
		wt(8);
		chk("osc_run", o_osc_enable, 8'h01);
	endtask : t_osc

	task automatic t_alarm();
		wr(7'h00, 8'h3c);
		i_alarm_match <= 1'b1;
		wt(8);
		i_alarm_match <= 1'b0;
		rd(7'h0e, 8'h81, "alarm_set");
		chk("no_irq", o_wave_irq_pin_oe_n, 8'h01);
		wr(7'h00, 8'h3d);
		chk("irq", o_wave_irq_pin_oe_n, 8'h00);
		wr(7'h0e, 8'h01);
		rd(7'h0e, 8'h01, "flag_w1");
		wr(7'h0e, 8'h80);
		rd(7'h0e, 8'h00, "flag_w0");
		chk("irq_off", o_wave_irq_pin_oe_n, 8'h01);
		i_osc_running <= 1'b0;
		wt(8);
		i_osc_running <= 1'b1;
		rd(7'h0e, 8'h80, "halted");
	endtask : t_alarm

	task automatic t_wave();
		for (int r = 0; r < 4; r++) begin
			wr(7'h00, {3'b001, r[1:0], 3'b000});
			i_wave_taps <= ~(4'h1 << r);
			wt(8);
			chk("wave_lo", o_wave_irq_pin_oe_n, 8'h00);
			i_wave_taps <= 4'h1 << r;
			wt(8);
			chk("wave_hi", o_wave_irq_pin_oe_n, 8'h01);
		end
		i_wave_taps <= 4'h0;
		i_vcc_valid <= 1'b0;
		wt(8);
		chk("bb_on", o_wave_irq_pin_oe_n, 8'h00);
		i_vcc_valid <= 1'b1;
		wt(8);
		wr(7'h00, 8'h18);
		i_vcc_valid <= 1'b0;
		wt(8);
		chk("bb_off", o_wave_irq_pin_oe_n, 8'h01);
		i_vcc_valid <= 1'b1;
		wt(8);
	endtask : t_wave

	task automatic t_charge();
		logic [11:0] tv [9] = '{12'ha59, 12'haae, 12'ha7b, 12'ha9d,
			12'ha40, 12'ha10, 12'had0, 12'h550, 12'hf50};
		logic [3:0] g;
		foreach (tv[i]) begin
			wr(7'h0f, tv[i][11:4]);
			g = {o_charge_enable, o_charge_diode, o_charge_res_sel};
			chk("charge", g, tv[i][3:0]);
		end
	endtask : t_charge

	task automatic close_out();
		if (err_total == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : close_out

	initial begin
		fork
			rcs_host_i.idle_clk();
			wt(12);
		join
		i_rst <= 1'b0;
		wt(12);
		t_reset();
		t_osc();
		t_alarm();
		t_wave();
		t_charge();
		close_out();
	end
endmodule : testbench

`default_nettype wire
